// ===== rtl/reload_irq_consts.svh
// Purpose: Constants for the reload interrupt and wake-up logic
// Assumes: AXI4-Lite word registers, 200 MHz system clock
// Notes: Offsets are byte addresses
`ifndef RELOAD_IRQ_CONSTS_SVH
`define RELOAD_IRQ_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_CTRL 4'h0
`define OFS_FLAGS 4'h4
`define OFS_IRQ_STATUS 4'h8
`define OFS_IRQ_MASK 4'hC

// ****************************************
// Field positions
// ****************************************
`define CTRL_GIE_BIT 0
`define CTRL_RELOAD_EN_BIT 1
`define FLAG_RELOAD_BIT 0
`define FLAG_EXT_BIT 1
`define EV_ACK_BIT 0
`define EV_WAKE_BIT 1

// ****************************************
// Vectors and reset values
// ****************************************
`define NUM_SRC 2
`define ADDR_W 12
`define VEC_RELOAD 12'h010
`define VEC_EXT 12'h004
`define CTRL_RESET 2'h0

`endif

// ===== rtl/reload_irq_pkg.sv
// Purpose: Types for the reload interrupt and wake-up logic
// Assumes: Included constants header
// Notes: Types only
package reload_irq_pkg;
  typedef enum logic [1:0] {
    RESP_OKAY = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_e;
endpackage

// ===== rtl/reload_irq_and_wakeup_logic.sv
// Purpose: Reload data interrupt request, acknowledge, global enable and wake-up
// Assumes: Core asserts instr_boundary once per instruction; stack_full from core
// Notes: Source 0 is the reload interrupt (highest priority), source 1 a generic one
// What this block does
// - Set reload flag when pointer reload completes
// - Branch only with both enables, flag, stack free
// - Servicing clears the reload flag in hardware
// - Servicing clears the global interrupt enable
// - Any source event on a clear flag produces a wake-up
// - Wake-up ignores all enable bits
// - Set flags stay until serviced or cleared
// - Cleared individual enable blocks service
// - Entry pushes only program counter
// - Interrupt return pops and sets global enable
// - Subroutine return pops, leaves enable clear
// - Blocked requests stay latched for later
// - Full stack blocks every acknowledge
// - Acknowledge pushes counter, loads own vector
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "reload_irq_consts.svh"

module reload_irq_and_wakeup_logic (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reload_done,
  input wire logic ext_event,
  input wire logic stack_full,
  input wire logic instr_boundary,
  input wire logic return_from_irq_instr,
  input wire logic subroutine_return_instr,
  output logic irq_take,
  output logic [`ADDR_W-1:0] irq_vector,
  output logic push_pc,
  output logic wakeup,
  output logic global_irq_enable,
  output logic irq
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************
  // Bus slave
  // ****************************************
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic reload_irq_enable;
  logic ext_irq_enable;
  logic [`NUM_SRC-1:0] flags;
  logic [1:0] ev_status;
  logic [1:0] ev_mask;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[3:0];
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= reload_irq_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr[1:0] == 2'h0) ? reload_irq_pkg::RESP_OKAY : reload_irq_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_ctrl;
  logic wr_flags;
  logic wr_status;
  logic wr_mask;
  assign wr_ctrl = wr_fire && w_strb[0] && aw_addr == `OFS_CTRL;
  assign wr_flags = wr_fire && w_strb[0] && aw_addr == `OFS_FLAGS;
  assign wr_status = wr_fire && w_strb[0] && aw_addr == `OFS_IRQ_STATUS;
  assign wr_mask = wr_fire && w_strb[0] && aw_addr == `OFS_IRQ_MASK;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= reload_irq_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= reload_irq_pkg::RESP_OKAY;
      // Addresses above the register window must not alias onto it
      if (s_axi_araddr[31:4] != 28'h0) begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= reload_irq_pkg::RESP_SLVERR;
      end else begin
        unique case (s_axi_araddr[3:0])
          `OFS_CTRL: s_axi_rdata <= {29'h0, ext_irq_enable, reload_irq_enable, global_irq_enable};
          `OFS_FLAGS: s_axi_rdata <= {30'h0, flags};
          `OFS_IRQ_STATUS: s_axi_rdata <= {30'h0, ev_status};
          `OFS_IRQ_MASK: s_axi_rdata <= {30'h0, ev_mask};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= reload_irq_pkg::RESP_SLVERR;
          end
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Request flags and enables
  // ****************************************
  logic [`NUM_SRC-1:0] src_ev;
  logic [`NUM_SRC-1:0] src_en;
  logic [`NUM_SRC-1:0] grant;
  logic [`NUM_SRC-1:0] flags_q;
  logic can_take;

  assign src_ev = {ext_event, reload_done};
  assign src_en = {ext_irq_enable, reload_irq_enable};

  // Global enable plus stack room plus boundary; individual enable per source
  assign can_take = instr_boundary && global_irq_enable && !stack_full;
  // Lowest index wins
  assign grant[0] = can_take && flags[0] && src_en[0];
  assign grant[1] = can_take && flags[1] && src_en[1] && !grant[0];
  assign irq_take = |grant;
  // Only the counter is pushed; no other context is saved here
  assign push_pc = irq_take;

  // Events are registered so a flag rises the cycle after its source
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= {`NUM_SRC{1'b0}};
    end else begin
      for (int i = 0; i < `NUM_SRC; i++) begin
        if (src_ev[i]) begin
          flags[i] <= 1'b1;
        end else if (grant[i]) begin
          flags[i] <= 1'b0;
        end else if (wr_flags) begin
          flags[i] <= w_data[i];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_vector <= `VEC_EXT;
    end else if (grant[0]) begin
      irq_vector <= `VEC_RELOAD;
    end else if (grant[1]) begin
      irq_vector <= `VEC_EXT;
    end
  end

  // Hardware clear on entry wins over a software write in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_irq_enable <= 1'b0;
      reload_irq_enable <= 1'b0;
      ext_irq_enable <= 1'b0;
    end else begin
      if (irq_take) begin
        global_irq_enable <= 1'b0;
      end else if (return_from_irq_instr) begin
        global_irq_enable <= 1'b1;
      end else if (wr_ctrl) begin
        global_irq_enable <= w_data[`CTRL_GIE_BIT];
      end
      // Subroutine return touches nothing here
      if (wr_ctrl) begin
        reload_irq_enable <= w_data[`CTRL_RELOAD_EN_BIT];
        ext_irq_enable <= w_data[2];
      end
    end
  end

  // ****************************************
  // Wake-up
  // ****************************************
  // Combinational so it works with the clock stopped; a preset flag cannot rise
  assign wakeup = |(src_ev & ~flags);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= {`NUM_SRC{1'b0}};
    end else begin
      flags_q <= flags;
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  logic [1:0] ev_set;
  assign ev_set = {|(flags & ~flags_q), irq_take};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_status <= 2'h0;
      ev_mask <= 2'h0;
    end else begin
      ev_status <= ev_set | (ev_status & ~(wr_status ? w_data[1:0] : 2'h0));
      if (wr_mask) begin
        ev_mask <= w_data[1:0];
      end
    end
  end

  assign irq = |(ev_status & ev_mask);

endmodule
`default_nettype wire

// ===== verification/reload_irq_checker.sv
// Purpose: Port-level assertions for the reload interrupt logic
// Assumes: Single clock domain, async active-low reset
// Notes: Bound to the design after the module
`timescale 1ns/1ps
`default_nettype none
`include "reload_irq_consts.svh"
module reload_irq_checker (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic reload_done,
  input wire logic ext_event,
  input wire logic stack_full,
  input wire logic instr_boundary,
  input wire logic return_from_irq_instr,
  input wire logic subroutine_return_instr,
  input wire logic irq_take,
  input wire logic [`ADDR_W-1:0] irq_vector,
  input wire logic push_pc,
  input wire logic wakeup,
  input wire logic global_irq_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_ack;
    irq_take ##1 !global_irq_enable;
  endsequence
  AST_PUSH: assert property (push_pc == irq_take) else $error("push differs from take");
  AST_ACK: assert property (irq_take |-> s_ack) else $error("enable kept after take");
  AST_GIE: assert property (irq_take |-> global_irq_enable) else $error("take without enable");
  AST_FULL: assert property (stack_full |-> !irq_take) else $error("take on full stack");
  AST_BOUND: assert property (!instr_boundary |-> !irq_take) else $error("take off boundary");
  AST_VEC: assert property (irq_take |=> (irq_vector == `VEC_RELOAD || irq_vector == `VEC_EXT))
    else $error("bad vector");
  AST_RETURN_FROM_IRQ_INSTR: assert property (return_from_irq_instr && !irq_take |=> global_irq_enable)
    else $error("return left enable low");
  AST_RET: assert property (subroutine_return_instr && !return_from_irq_instr && !global_irq_enable
    |=> !global_irq_enable) else $error("plain return set enable");
  AST_WAKE: assert property (wakeup |-> reload_done || ext_event) else $error("wake without event");
endmodule
bind reload_irq_and_wakeup_logic reload_irq_checker CHK (.sys_clk, .arst_n, .reload_done, .ext_event,
  .stack_full, .instr_boundary, .return_from_irq_instr, .subroutine_return_instr, .irq_take,
  .irq_vector, .push_pc, .wakeup, .global_irq_enable);
`default_nettype wire

// ===== verification/core_model.sv
// Purpose: Core sequencer with a small return stack
// Assumes: One level used by main code, one free
// Notes: Vector fetch cycle is not an instruction boundary
`timescale 1ns/1ps
`default_nettype none
module core_model #(parameter int DEPTH = 2) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic push_pc,
  input wire logic call_req,
  input wire logic ret_req,
  input wire logic return_from_irq_instr_sel,
  output logic instr_boundary,
  output logic stack_full,
  output logic return_from_irq_instr,
  output logic subroutine_return_instr,
  output logic [1:0] depth
);
  logic fetch;
  assign instr_boundary = !fetch;
  assign stack_full = (depth == 2'(DEPTH));
  assign return_from_irq_instr = ret_req && return_from_irq_instr_sel;
  assign subroutine_return_instr = ret_req && !return_from_irq_instr_sel;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fetch <= 1'b0;
      depth <= 2'h0;
    end else begin
      fetch <= push_pc;
      // Only the counter is stacked; calls share the same levels
      if (push_pc || call_req) depth <= depth + 2'h1;
      else if (ret_req && depth != 2'h0) depth <= depth - 2'h1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/reload_irq_and_wakeup_logic_bench.sv
// Purpose: Self-checking bench for the reload interrupt logic
// Assumes: Core model drives boundaries, stack and returns
// Notes: Event mask order is {ext, reload}
`timescale 1ns/1ps
`default_nettype none
`include "reload_irq_consts.svh"
module reload_irq_and_wakeup_logic_bench;
  logic sys_clk = 1'b0;
  logic arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, reload_done, ext_event, stack_full;
  logic instr_boundary, return_from_irq_instr, subroutine_return_instr, irq_take, push_pc, wakeup;
  logic global_irq_enable, irq, call_req, ret_req, return_from_irq_instr_sel;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, depth, rsp;
  logic [`ADDR_W-1:0] irq_vector;
  int num_errors = 0;
  int n_tests = 0;
  always #2.5 sys_clk = ~sys_clk;
  reload_irq_and_wakeup_logic DUT (.*);
  core_model CORE (.*);
  task automatic chk(input string n, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic ev(input logic [1:0] m, input logic w);
    @(posedge sys_clk);
    {ext_event, reload_done} <= m;
    #1 chk("wakeup", wakeup, w);
    @(posedge sys_clk);
    {ext_event, reload_done} <= 2'h0;
    #1;
  endtask
  task automatic ret(input logic s);
    @(posedge sys_clk);
    ret_req <= 1'b1;
    return_from_irq_instr_sel <= s;
    @(posedge sys_clk);
    ret_req <= 1'b0;
    #1;
  endtask
  task automatic vec(input logic [11:0] v);
    chk("take", irq_take, 1'b1);
    @(posedge sys_clk);
    #1 chk("vector", irq_vector, v);
    chk("gie", global_irq_enable, 1'b0);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_reset;
    chk("gie", global_irq_enable, 1'b0);
    chk("vector", irq_vector, `VEC_EXT);
    rd(`OFS_CTRL);
    chk("ctrl", rd_v, 32'h0);
    rd(32'h10);
    chk("unmapped", rsp, reload_irq_pkg::RESP_SLVERR);
  endtask
  task automatic s_disabled;
    wr(`OFS_CTRL, 32'h1);
    ev(2'h1, 1'b1);
    chk("take", irq_take, 1'b0);
    rd(`OFS_FLAGS);
    chk("flag", rd_v[0], 1'b1);
    rd(`OFS_IRQ_STATUS);
    chk("status", rd_v[1], 1'b1);
    wr(`OFS_IRQ_MASK, 32'h2);
    chk("irq", irq, 1'b1);
    wr(`OFS_IRQ_STATUS, 32'h2);
    chk("irq", irq, 1'b0);
    wr(`OFS_FLAGS, 32'h1); // Preset flag to suppress wake
    ev(2'h1, 1'b0);
    wr(`OFS_FLAGS, 32'h0);
  endtask
  task automatic s_take;
    wr(`OFS_CTRL, 32'h3);
    ev(2'h1, 1'b1);
    vec(`VEC_RELOAD);
    rd(`OFS_FLAGS);
    chk("flag", rd_v[0], 1'b0);
    chk("depth", depth, 2'h1);
  endtask
  task automatic s_blocked;
    ev(2'h1, 1'b1);
    chk("take", irq_take, 1'b0);
    ret(1'b0);
    chk("gie", global_irq_enable, 1'b0);
    ret(1'b1);
    vec(`VEC_RELOAD);
  endtask
  task automatic s_full;
    ret(1'b1);
    @(posedge sys_clk);
    call_req <= 1'b1;
    repeat (2) @(posedge sys_clk);
    call_req <= 1'b0;
    wr(`OFS_CTRL, 32'h7);
    ev(2'h3, 1'b1);
    chk("take", irq_take, 1'b0);
    ret(1'b0);
    vec(`VEC_RELOAD);
    ret(1'b1);
    vec(`VEC_EXT);
  endtask
  task automatic final_report;
    if (num_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {reload_done, ext_event, call_req, ret_req, return_from_irq_instr_sel} = 5'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    s_reset;
    s_disabled;
    s_take;
    s_blocked;
    s_full;
    final_report;
  end
  initial begin
    #20000;
    num_errors++;
    final_report;
  end
endmodule
`default_nettype wire
